// ==== mrra_pkg.sv ====
// Shared constants and types of the multirate link rate adapter
package mrra_pkg;
  // Oversampling
  localparam int OS_FACTOR = 5;
  localparam int OS_CENTRE = 2;
  localparam int SYM_BITS  = 10;
  // Coding sublayer to serdes analog layer widths and transmit lane enables
  localparam logic [4:0] CIF_W_ONE   = 5'h0a;
  localparam logic [4:0] CIF_W_MULTI = 5'h14;
  localparam logic [3:0] TX_LANE_ALL = 4'hf;
  // Pin synchroniser slots
  localparam int PIN_N     = 6;
  localparam int PIN_REF   = 0;
  localparam int PIN_LOCK  = 1;
  localparam int PIN_RXREC = 2;
  localparam int PIN_RXLS  = 3;
  localparam int PIN_TXLS  = 4;
  localparam int PIN_TXP   = 5;
  // Rate detection
  localparam int           MEAS_WIN_CYC = 1024;
  localparam logic [11:0]  BAND_TH_LOW  = 12'h040;
  localparam logic [11:0]  BAND_TH_MID  = 12'h0c0;
  localparam logic [1:0]   BAND_OS      = 2'h0;
  localparam logic [1:0]   BAND_MID     = 2'h1;
  localparam logic [1:0]   BAND_HIGH    = 2'h2;
  // Reconfiguration port
  localparam int            RCFG_AW        = 10;
  localparam int            RCFG_DW        = 32;
  localparam logic [9:0]    RCFG_BAND_ADDR = 10'h040;
  localparam logic [31:0]   RCFG_BAND_MASK = 32'h0000_0003;
  localparam logic [2:0]    FLUSH_CYC      = 3'h4;
  typedef enum {RC_IDLE, RC_RD, RC_WR, RC_SETTLE} mrra_rcfg_e;
  typedef enum {OWN_NONE, OWN_RX, OWN_TX} mrra_own_e;
endpackage

// ==== mrra_stream_if.sv ====
// Valid/ready word stream between adapter modules
`timescale 1ns/100ps
interface mrra_stream_if #(parameter int W = 20) ();
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ==== mrra_rx_os.sv ====
// Receive 5x oversampler: centre-sample bit recovery
`timescale 1ns/100ps
module mrra_rx_os #(
  parameter int W = 20
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         in_en,
  input  wire logic [W-1:0] in_data,
  mrra_stream_if.src        out
);
  localparam int NB = W * mrra_pkg::OS_FACTOR;
  logic [NB-1:0] sbuf_reg;
  logic [NB-1:0] full_w;
  logic [2:0]    cnt_reg;
  logic [W-1:0]  word_reg;
  logic          valid_reg;
  logic [W-1:0]  pick_w;

  assign full_w = {in_data, sbuf_reg[NB-1:W]};

  always_comb begin
    for (int i = 0; i < W; i++) begin
      pick_w[i] = full_w[i*mrra_pkg::OS_FACTOR + mrra_pkg::OS_CENTRE]; // RULE23
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sbuf_reg  <= '0;
      cnt_reg   <= 3'h0;
      word_reg  <= '0;
      valid_reg <= 1'b0;
    end else if (ce) begin
      valid_reg <= 1'b0;
      if (in_en) begin
        sbuf_reg <= full_w;
        if (cnt_reg == 3'(mrra_pkg::OS_FACTOR - 1)) begin
          cnt_reg   <= 3'h0;
          word_reg  <= pick_w; // RULE5
          valid_reg <= 1'b1; // RULE8
        end else begin
          cnt_reg <= cnt_reg + 3'h1;
        end
      end
    end
  end

  assign out.data  = word_reg; // RULE6 RULE7
  assign out.valid = valid_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_os_gap;
    ce && out.valid |=> !out.valid;
  endproperty
  a_os_gap: assert property (p_os_gap) else $error("oversampler valid held"); // RULE8

  property p_os_five;
    $rose(out.valid) |-> $past(cnt_reg) == 3'h4 && $past(in_en);
  endproperty
  a_os_five: assert property (p_os_five) else $error("valid not on fifth word"); // RULE8
endmodule

// ==== mrra_xfifo.sv ====
// Cross clock FIFO with strobe-qualified write and read sides
`timescale 1ns/100ps
module mrra_xfifo #(
  parameter int W  = 20,
  parameter int AW = 4
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic flush,
  mrra_stream_if.snk wr,
  mrra_stream_if.src rd
);
  localparam int DEPTH = 1 << AW;
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wptr_reg;
  logic [AW:0]  rptr_reg;
  logic [AW:0]  cnt_w;
  logic         wr_go;
  logic         rd_go;

  assign cnt_w    = wptr_reg - rptr_reg;
  assign wr.ready = (cnt_w != (AW+1)'(DEPTH)) && !flush;
  assign rd.valid = (cnt_w != '0) && !flush;
  assign rd.data  = mem[rptr_reg[AW-1:0]];
  assign wr_go    = wr.valid && wr.ready;
  assign rd_go    = rd.valid && rd.ready;

  always_ff @(posedge clk) begin
    if (ce && wr_go) begin
      mem[wptr_reg[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else if (ce) begin
      if (flush) begin
        wptr_reg <= '0;
        rptr_reg <= '0;
      end else begin
        if (wr_go) begin
          wptr_reg <= wptr_reg + (AW+1)'(1); // RULE9 RULE10
        end
        if (rd_go) begin
          rptr_reg <= rptr_reg + (AW+1)'(1);
        end
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_fifo_bound;
    cnt_w <= (AW+1)'(DEPTH);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("fifo overflow"); // RULE9
endmodule

// ==== mrra_top.sv ====
// Multirate link rate adapter: rate detect, reconfig, oversampling, FIFOs
//
// What this block does
// RULE1: Receive path covers any rate in range
// RULE2: Measure reference clock and classify band
// RULE3: Reconfigure PLL and transceiver per band
// RULE4: Reconfigure on new clock or lock loss
// RULE5: Below minimum rate, oversampler recovers bits
// RULE6: Factor fixed at five, width programmable
// RULE7: Twenty bits two symbols, forty four
// RULE8: Valid pulse once every five cycles
// RULE9: Receive FIFO crosses recovered to link clock
// RULE10: Transmit FIFO crosses link to parallel clock
// RULE11: Oversampled mode writes on valid pulse
// RULE12: Direct mode writes every transceiver cycle
// RULE13: Processor selects transmit oversampler feed
// RULE14: Direct transmit reads FIFO every cycle
// RULE15: Partial reconfiguration is read then write
// RULE16: Master port links controller to reconfig
// RULE17: Arbitrate receive and transmit reconfig requests
// RULE18: Interface ten bits one symbol, else twenty
// RULE19: Byte serializer only for four symbols
// RULE20: Four bonded lanes, one PLL, one refclk
// RULE21: Transmit oversampler repeats each bit five
// RULE22: Enable pulse every fifth cycle reads FIFO
// RULE23: Recovered bit is the centre sample
// RULE24: Switch paths only while FIFO flushed
`timescale 1ns/100ps
module mrra_top #(
  parameter int SPC     = 2,
  parameter int FIFO_AW = 4
) (
  input  wire logic                         CLK,
  input  wire logic                         RST,
  input  wire logic                         CE,
  input  wire logic                         REFCLK_IN,
  input  wire logic                         XCVR_LOCKED,
  input  wire logic                         RX_RECCLK,
  input  wire logic [SPC*10-1:0]            RX_DATA,
  input  wire logic                         RX_LSCLK,
  output logic      [SPC*10-1:0]            RX_OUT_DATA,
  output logic                              RX_OUT_VALID,
  input  wire logic                         TX_LSCLK,
  input  wire logic [SPC*10-1:0]            TX_IN_DATA,
  input  wire logic                         TX_PCLK,
  input  wire logic                         TX_OS_MODE,
  output logic      [SPC*10-1:0]            TX_XCVR_DATA,
  output logic      [mrra_pkg::RCFG_AW-1:0] RCFG_ADDR,
  output logic                              RCFG_READ,
  output logic                              RCFG_WRITE,
  output logic      [mrra_pkg::RCFG_DW-1:0] RCFG_WDATA,
  input  wire logic [mrra_pkg::RCFG_DW-1:0] RCFG_RDATA,
  input  wire logic                         RCFG_RVALID,
  input  wire logic                         RCFG_WAITREQ,
  input  wire logic                         TX_RCFG_REQ,
  input  wire logic [mrra_pkg::RCFG_AW-1:0] TX_RCFG_ADDR,
  input  wire logic [mrra_pkg::RCFG_DW-1:0] TX_RCFG_WDATA,
  output logic                              TX_RCFG_DONE,
  output logic      [1:0]                   RATE_BAND,
  output logic      [1:0]                   PLL_BAND,
  output logic                              RX_OS_ACTIVE,
  output logic                              RCFG_BUSY,
  output logic      [4:0]                   CODING_IF_WIDTH,
  output logic                              TX_SERIALIZER_EN,
  output logic      [3:0]                   TX_LANE_EN
);
  localparam int W  = SPC * mrra_pkg::SYM_BITS;
  localparam int CH = W / mrra_pkg::OS_FACTOR;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detect
  logic [mrra_pkg::PIN_N-1:0] pin_w;
  logic [mrra_pkg::PIN_N-1:0] s1_reg;
  logic [mrra_pkg::PIN_N-1:0] s2_reg;
  logic [mrra_pkg::PIN_N-1:0] s3_reg;
  logic [mrra_pkg::PIN_N-1:0] lvl_reg;
  logic [mrra_pkg::PIN_N-1:0] lvl_d_reg;
  logic [mrra_pkg::PIN_N-1:0] rise_w;
  logic                       lock_fall_w;

  assign pin_w = {TX_PCLK, TX_LSCLK, RX_LSCLK, RX_RECCLK, XCVR_LOCKED, REFCLK_IN};

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      lvl_reg   <= '0;
      lvl_d_reg <= '0;
    end else if (CE) begin
      s1_reg    <= pin_w;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      lvl_reg   <= (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
      lvl_d_reg <= lvl_reg;
    end
  end

  assign rise_w      = lvl_reg & ~lvl_d_reg;
  assign lock_fall_w = lvl_d_reg[mrra_pkg::PIN_LOCK] & ~lvl_reg[mrra_pkg::PIN_LOCK];

  ////////////////////////////////////////////////////////////////////////////
  // Rate detection
  logic [9:0]  win_reg;
  logic [11:0] edges_reg;
  logic [1:0]  band_w;
  logic        seen_reg;
  logic        pend_reg;
  logic        win_end_w;
  logic        trig_w;

  assign win_end_w = (win_reg == 10'(mrra_pkg::MEAS_WIN_CYC - 1));
  // Bands span the whole supported rate range
  assign band_w = (edges_reg < mrra_pkg::BAND_TH_LOW) ? mrra_pkg::BAND_OS : // RULE1
                  (edges_reg < mrra_pkg::BAND_TH_MID) ? mrra_pkg::BAND_MID :
                  mrra_pkg::BAND_HIGH; // RULE2
  assign trig_w = (win_end_w && edges_reg != '0 && (!seen_reg || band_w != RATE_BAND))
                  || (lock_fall_w && seen_reg); // RULE4

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      win_reg   <= '0;
      edges_reg <= '0;
      seen_reg  <= 1'b0;
      RATE_BAND <= mrra_pkg::BAND_HIGH;
    end else if (CE) begin
      win_reg <= win_reg + 10'h001;
      if (win_end_w) begin
        edges_reg <= '0;
        if (edges_reg != '0) begin
          RATE_BAND <= band_w; // RULE2
          seen_reg  <= 1'b1;
        end
      end else if (rise_w[mrra_pkg::PIN_REF]) begin
        edges_reg <= edges_reg + 12'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reconfiguration sequence
  mrra_pkg::mrra_rcfg_e       rc_reg;
  logic [1:0]                 tgt_reg;
  logic [mrra_pkg::RCFG_DW-1:0] rmw_reg;
  logic [2:0]                 flush_cnt_reg;
  logic                       rx_req_w;
  logic                       rx_done_reg;

  assign rx_req_w = (rc_reg == mrra_pkg::RC_RD) || (rc_reg == mrra_pkg::RC_WR);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pend_reg <= 1'b0;
    end else if (CE) begin
      if (trig_w) begin
        pend_reg <= 1'b1; // RULE4
      end else if (rc_reg == mrra_pkg::RC_IDLE) begin
        pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rc_reg        <= mrra_pkg::RC_IDLE;
      tgt_reg       <= mrra_pkg::BAND_HIGH;
      rmw_reg       <= '0;
      flush_cnt_reg <= 3'h0;
      PLL_BAND      <= mrra_pkg::BAND_HIGH;
      RX_OS_ACTIVE  <= 1'b0;
      RCFG_BUSY     <= 1'b0;
    end else if (CE) begin
      case (rc_reg)
        mrra_pkg::RC_IDLE: begin
          RCFG_BUSY <= pend_reg;
          if (pend_reg) begin
            tgt_reg  <= RATE_BAND;
            PLL_BAND <= RATE_BAND; // RULE3
            rc_reg   <= mrra_pkg::RC_RD;
          end
        end
        mrra_pkg::RC_RD: begin
          if (rx_done_reg) begin
            // Keep every bit outside the band field
            rmw_reg <= (RCFG_RDATA & ~mrra_pkg::RCFG_BAND_MASK)
                       | {30'h0, tgt_reg}; // RULE15
            rc_reg  <= mrra_pkg::RC_WR;
          end
        end
        mrra_pkg::RC_WR: begin
          if (rx_done_reg) begin
            flush_cnt_reg <= 3'h0;
            rc_reg        <= mrra_pkg::RC_SETTLE;
          end
        end
        mrra_pkg::RC_SETTLE: begin
          flush_cnt_reg <= flush_cnt_reg + 3'h1;
          if (flush_cnt_reg == mrra_pkg::FLUSH_CYC) begin
            RX_OS_ACTIVE <= (tgt_reg == mrra_pkg::BAND_OS); // RULE24 RULE5
            RCFG_BUSY    <= 1'b0;
            rc_reg       <= mrra_pkg::RC_IDLE;
          end
        end
        default: rc_reg <= mrra_pkg::RC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reconfiguration master and receive/transmit arbiter
  mrra_pkg::mrra_own_e own_reg;
  logic                tx_pend_reg;
  logic                rd_wait_reg;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      own_reg      <= mrra_pkg::OWN_NONE;
      tx_pend_reg  <= 1'b0;
      rd_wait_reg  <= 1'b0;
      rx_done_reg  <= 1'b0;
      TX_RCFG_DONE <= 1'b0;
      RCFG_ADDR    <= '0;
      RCFG_READ    <= 1'b0;
      RCFG_WRITE   <= 1'b0;
      RCFG_WDATA   <= '0;
    end else if (CE) begin
      rx_done_reg  <= 1'b0;
      TX_RCFG_DONE <= 1'b0;
      if (TX_RCFG_REQ) begin
        tx_pend_reg <= 1'b1;
      end
      case (own_reg)
        mrra_pkg::OWN_NONE: begin
          if (rx_req_w && !rx_done_reg) begin
            own_reg    <= mrra_pkg::OWN_RX; // RULE16 RULE17
            RCFG_ADDR  <= mrra_pkg::RCFG_BAND_ADDR;
            RCFG_READ  <= (rc_reg == mrra_pkg::RC_RD);
            RCFG_WRITE <= (rc_reg == mrra_pkg::RC_WR);
            RCFG_WDATA <= rmw_reg;
          end else if (tx_pend_reg) begin
            own_reg     <= mrra_pkg::OWN_TX; // RULE17
            tx_pend_reg <= TX_RCFG_REQ;
            RCFG_ADDR   <= TX_RCFG_ADDR;
            RCFG_WRITE  <= 1'b1;
            RCFG_WDATA  <= TX_RCFG_WDATA;
          end
        end
        default: begin
          if ((RCFG_READ || RCFG_WRITE) && !RCFG_WAITREQ) begin
            RCFG_READ   <= 1'b0;
            RCFG_WRITE  <= 1'b0;
            rd_wait_reg <= RCFG_READ;
          end
          if ((RCFG_WRITE && !RCFG_WAITREQ) || (rd_wait_reg && RCFG_RVALID)) begin
            rd_wait_reg  <= 1'b0;
            own_reg      <= mrra_pkg::OWN_NONE;
            rx_done_reg  <= (own_reg == mrra_pkg::OWN_RX);
            TX_RCFG_DONE <= (own_reg == mrra_pkg::OWN_TX);
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive path
  mrra_stream_if #(.W(W)) rx_os_if ();
  mrra_stream_if #(.W(W)) rx_wr_if ();
  mrra_stream_if #(.W(W)) rx_rd_if ();
  logic rx_flush_w;
  logic rx_os_rst_reg;

  assign rx_flush_w = (rc_reg != mrra_pkg::RC_IDLE); // RULE24

  // Restart word alignment on every path switch
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rx_os_rst_reg <= 1'b1;
    end else if (CE) begin
      rx_os_rst_reg <= rx_flush_w; // RULE24
    end
  end

  mrra_rx_os #(.W(W)) u_rx_os (
    .clk     (CLK),
    .rst     (rx_os_rst_reg),
    .ce      (CE),
    .in_en   (rise_w[mrra_pkg::PIN_RXREC]),
    .in_data (RX_DATA),
    .out     (rx_os_if)
  );

  assign rx_os_if.ready = rx_wr_if.ready;
  assign rx_wr_if.data  = RX_OS_ACTIVE ? rx_os_if.data : RX_DATA; // RULE11
  assign rx_wr_if.valid = RX_OS_ACTIVE ? rx_os_if.valid
                                       : rise_w[mrra_pkg::PIN_RXREC]; // RULE12
  assign rx_rd_if.ready = rise_w[mrra_pkg::PIN_RXLS];

  mrra_xfifo #(.W(W), .AW(FIFO_AW)) u_rx_fifo (
    .clk   (CLK),
    .rst   (RST),
    .ce    (CE),
    .flush (rx_flush_w),
    .wr    (rx_wr_if),
    .rd    (rx_rd_if)
  );

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RX_OUT_DATA  <= '0;
      RX_OUT_VALID <= 1'b0;
    end else if (CE) begin
      RX_OUT_VALID <= rx_rd_if.valid && rx_rd_if.ready; // RULE9
      if (rx_rd_if.valid && rx_rd_if.ready) begin
        RX_OUT_DATA <= rx_rd_if.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path
  mrra_stream_if #(.W(W)) tx_wr_if ();
  mrra_stream_if #(.W(W)) tx_rd_if ();
  logic         tx_mode_reg;
  logic         tx_flush_reg;
  logic [2:0]   tx_ph_reg;
  logic [W-1:0] tx_word_reg;
  logic [W-1:0] rep_w;
  logic [W-1:0] tx_src_w;
  logic         txp_w;
  logic         tx_ce_w;

  assign txp_w   = rise_w[mrra_pkg::PIN_TXP];
  assign tx_ce_w = txp_w && (tx_ph_reg == 3'h0); // RULE22
  assign tx_wr_if.data  = TX_IN_DATA;
  assign tx_wr_if.valid = rise_w[mrra_pkg::PIN_TXLS];
  assign tx_rd_if.ready = tx_mode_reg ? tx_ce_w : txp_w; // RULE14

  mrra_xfifo #(.W(W), .AW(FIFO_AW)) u_tx_fifo (
    .clk   (CLK),
    .rst   (RST),
    .ce    (CE),
    .flush (tx_flush_reg),
    .wr    (tx_wr_if),
    .rd    (tx_rd_if)
  );

  // Phase 0 takes the word being popped now
  assign tx_src_w = (tx_ph_reg != 3'h0) ? tx_word_reg
                  : (tx_rd_if.valid ? tx_rd_if.data : '0);

  always_comb begin
    for (int i = 0; i < W; i++) begin
      rep_w[i] = tx_src_w[32'(tx_ph_reg) * CH + i / mrra_pkg::OS_FACTOR]; // RULE21
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_mode_reg  <= 1'b0;
      tx_flush_reg <= 1'b0;
    end else if (CE) begin
      tx_flush_reg <= (TX_OS_MODE != tx_mode_reg);
      if (tx_flush_reg) begin
        tx_mode_reg <= TX_OS_MODE; // RULE13 RULE24
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_ph_reg    <= 3'h0;
      tx_word_reg  <= '0;
      TX_XCVR_DATA <= '0;
    end else if (CE) begin
      if (tx_flush_reg) begin
        tx_ph_reg <= 3'h0; // RULE24
      end else if (txp_w) begin
        tx_ph_reg <= (tx_ph_reg == 3'(mrra_pkg::OS_FACTOR - 1)) ? 3'h0 : tx_ph_reg + 3'h1;
      end
      if (txp_w) begin
        if (tx_mode_reg) begin
          TX_XCVR_DATA <= rep_w; // RULE13
        end else begin
          TX_XCVR_DATA <= tx_rd_if.valid ? tx_rd_if.data : '0; // RULE10
        end
      end
      if (tx_ce_w) begin
        tx_word_reg <= tx_rd_if.valid ? tx_rd_if.data : '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Static transceiver configuration
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CODING_IF_WIDTH  <= (SPC == 1) ? mrra_pkg::CIF_W_ONE : mrra_pkg::CIF_W_MULTI; // RULE18
      TX_SERIALIZER_EN <= (SPC == 4); // RULE19
      TX_LANE_EN       <= mrra_pkg::TX_LANE_ALL; // RULE20
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  property p_flush_busy;
    rc_reg != mrra_pkg::RC_IDLE |-> !rx_wr_if.ready && !rx_rd_if.valid;
  endproperty
  a_flush_busy: assert property (p_flush_busy) else $error("rx fifo open in reconfig"); // RULE24

  sequence s_rd_phase;
    RCFG_READ && own_reg == mrra_pkg::OWN_RX;
  endsequence
  property p_rd_hold;
    s_rd_phase ##0 RCFG_WAITREQ |=> RCFG_READ && $stable(RCFG_ADDR);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read dropped in stall"); // RULE16
  property p_rmw;
    RCFG_WRITE && own_reg == mrra_pkg::OWN_RX |->
      RCFG_WDATA[1:0] == tgt_reg && RCFG_ADDR == mrra_pkg::RCFG_BAND_ADDR;
  endproperty
  a_rmw: assert property (p_rmw) else $error("reconfig write wrong field"); // RULE3

  property p_read_first;
    CE && rc_reg == mrra_pkg::RC_RD ##1 rc_reg == mrra_pkg::RC_WR |->
      $past(rx_done_reg);
  endproperty
  a_read_first: assert property (p_read_first) else $error("write before read"); // RULE15

  property p_lock_trig;
    CE && lock_fall_w && seen_reg |=> pend_reg;
  endproperty
  a_lock_trig: assert property (p_lock_trig) else $error("lock loss ignored"); // RULE4

  property p_tx_five;
    CE && tx_mode_reg && tx_rd_if.ready |=> !tx_rd_if.ready [*4];
  endproperty
  a_tx_five: assert property (p_tx_five) else $error("tx read too often"); // RULE22

  property p_tx_direct;
    !tx_mode_reg && txp_w |-> tx_rd_if.ready;
  endproperty
  a_tx_direct: assert property (p_tx_direct) else $error("direct read missed"); // RULE14

  property p_tx_own;
    own_reg == mrra_pkg::OWN_TX |-> !RCFG_READ;
  endproperty
  a_tx_own: assert property (p_tx_own) else $error("tx owner reading"); // RULE17

  property p_os_sel;
    CE && rc_reg == mrra_pkg::RC_SETTLE ##1 rc_reg == mrra_pkg::RC_IDLE |->
      RX_OS_ACTIVE == (tgt_reg == mrra_pkg::BAND_OS);
  endproperty
  a_os_sel: assert property (p_os_sel) else $error("oversample mode wrong"); // RULE5
endmodule

// ==== mrra_rcfg_model.sv ====
// Reconfiguration slave model holding the band register
`timescale 1ns/100ps
module mrra_rcfg_model (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        SLOW,
  input  wire logic [9:0]  ADDR,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WDATA,
  output logic      [31:0] RDATA,
  output logic             RVALID,
  output logic             WAITREQ,
  output logic      [31:0] MEM,
  output logic      [31:0] LAST_WDATA
);
  logic [2:0] stall_reg;
  logic [1:0] rd_ph_reg;
  assign WAITREQ = (READ | WRITE) & (stall_reg != 3'h0);
  assign RVALID  = rd_ph_reg == 2'h1;
  // Read data stays briefly past valid, then shows inverted contents
  assign RDATA   = (rd_ph_reg != 2'h0) ? MEM : ~MEM;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) stall_reg <= 3'h0;
    else if (!(READ | WRITE)) stall_reg <= SLOW ? 3'h3 : 3'h0;
    else if (stall_reg != 3'h0) stall_reg <= stall_reg - 3'h1;
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) rd_ph_reg <= 2'h0;
    else if (READ && !WAITREQ) rd_ph_reg <= 2'h1;
    else if (rd_ph_reg != 2'h0) rd_ph_reg <= rd_ph_reg + 2'h1;
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      MEM <= 32'ha5a5_5a5e;
      LAST_WDATA <= 32'h0;
    end else if (WRITE && !WAITREQ) begin
      LAST_WDATA <= WDATA;
      if (ADDR == 10'h040) MEM <= WDATA;
    end
  end
endmodule

// ==== testbench.sv ====
// Self-checking bench of the multirate link rate adapter
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0, rst = 1'b1, refclk = 1'b0, locked = 1'b1, rxrec = 1'b0, rxls = 1'b0;
  logic txls = 1'b0, txp = 1'b0, txos = 1'b0, txreq = 1'b0, slow = 1'b0, ce = 1'b1;
  logic [19:0] rxd = 20'h0, txd = 20'h0, rxo, txo;
  logic [9:0] ra, txa = 10'h011;
  logic [31:0] rw, rr, txw = 32'h1234_5678, mem, lastw;
  logic rrd, rwr, rv, wq, done, rxv, busy, rxos, ser;
  logic [1:0] band, pband;
  logic [4:0] cifw;
  logic [3:0] lanes;
  int mismatches = 0, n_tests = 0, ref_half = 128;
  always #10 clk = ~clk;
  always begin
    if (ref_half == 0) #20;
    else #(ref_half) refclk = ~refclk;
  end
  mrra_top #(.SPC(2), .FIFO_AW(4)) u_dut (
    .CLK(clk), .RST(rst), .CE(ce), .REFCLK_IN(refclk), .XCVR_LOCKED(locked),
    .RX_RECCLK(rxrec), .RX_DATA(rxd), .RX_LSCLK(rxls), .RX_OUT_DATA(rxo),
    .RX_OUT_VALID(rxv), .TX_LSCLK(txls), .TX_IN_DATA(txd), .TX_PCLK(txp),
    .TX_OS_MODE(txos), .TX_XCVR_DATA(txo), .RCFG_ADDR(ra), .RCFG_READ(rrd),
    .RCFG_WRITE(rwr), .RCFG_WDATA(rw), .RCFG_RDATA(rr), .RCFG_RVALID(rv),
    .RCFG_WAITREQ(wq), .TX_RCFG_REQ(txreq), .TX_RCFG_ADDR(txa), .TX_RCFG_WDATA(txw),
    .TX_RCFG_DONE(done), .RATE_BAND(band), .PLL_BAND(pband), .RX_OS_ACTIVE(rxos),
    .RCFG_BUSY(busy), .CODING_IF_WIDTH(cifw), .TX_SERIALIZER_EN(ser), .TX_LANE_EN(lanes));
  mrra_rcfg_model u_rcfg (
    .CLK(clk), .RST(rst), .SLOW(slow), .ADDR(ra), .READ(rrd), .WRITE(rwr),
    .WDATA(rw), .RDATA(rr), .RVALID(rv), .WAITREQ(wq), .MEM(mem), .LAST_WDATA(lastw));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic hit(input int sel, input logic [1:0] v);
    case (sel)
      0: return band === v;
      1: return busy === v[0];
      2: return rxv === 1'b1;
      default: return done === 1'b1;
    endcase
  endfunction
  task automatic wait_on(input int sel, input logic [1:0] v, input int lim);
    for (int i = 0; i < lim && !hit(sel, v); i++) cyc(1);
    if (!hit(sel, v)) begin
      mismatches++;
      test_done;
    end
  endtask
  task automatic rx_word(input logic [19:0] d);
    rxd = d;
    rxrec = 1'b1;
    cyc(4);
    rxrec = 1'b0;
    cyc(4);
  endtask
  task automatic rx_pop(input logic [19:0] e);
    rxls = 1'b1;
    wait_on(2, 2'h0, 20);
    check(rxo, e);
    cyc(4);
    rxls = 1'b0;
    cyc(4);
  endtask
  task automatic tx_push(input logic [19:0] d);
    txd = d;
    txls = 1'b1;
    cyc(4);
    txls = 1'b0;
    cyc(4);
  endtask
  task automatic tx_pop(input logic [19:0] e);
    txp = 1'b1;
    cyc(4);
    txp = 1'b0;
    cyc(4);
    check(txo, e);
  endtask
  function automatic logic [19:0] spread(input logic [19:0] d, input int p);
    for (int i = 0; i < 20; i++) spread[i] = d[p*4+i/5];
  endfunction
  function automatic logic [19:0] ovs(input logic [19:0] t, input int j);
    for (int b = 0; b < 20; b++) ovs[b] = t[(20*j+b)/5];
  endfunction
  task automatic band_seq(input int half, input logic [1:0] b, input logic os);
    ref_half = half;
    wait_on(0, b, 3000);
    wait_on(1, 2'h1, 10);
    wait_on(1, 2'h0, 500);
    check(pband, b);
    check(mem, (32'ha5a5_5a5e & ~32'h3) | b);
    check(rxos, os);
  endtask
  initial begin
    cyc(12);
    rst = 1'b0;
    check(band, 2'h2);
    check(cifw, mrra_pkg::CIF_W_MULTI);
    check(ser, 1'b0);
    check(lanes, mrra_pkg::TX_LANE_ALL);
    band_seq(128, 2'h1, 1'b0);
    rx_word(20'h12345);
    rx_word(20'habcde);
    rx_pop(20'h12345);
    rx_pop(20'habcde);
    tx_push(20'h5a5a5);
    tx_pop(20'h5a5a5);
    tx_pop(20'h0);
    txos = 1'b1;
    cyc(4);
    tx_push(20'hc6a39);
    for (int p = 0; p < 5; p++) tx_pop(spread(20'hc6a39, p));
    ce = 1'b0;
    tx_pop(spread(20'hc6a39, 4));
    ce = 1'b1;
    slow = 1'b1;
    band_seq(320, 2'h0, 1'b1);
    for (int j = 0; j < 5; j++) rx_word(ovs(20'h9c3a5, j));
    rx_pop(20'h9c3a5);
    locked = 1'b0;
    wait_on(1, 2'h1, 20);
    locked = 1'b1;
    wait_on(1, 2'h0, 500);
    check(mem[1:0], 2'h0);
    txreq = 1'b1;
    cyc(1);
    txreq = 1'b0;
    wait_on(3, 2'h0, 60);
    check(lastw, txw);
    test_done;
  end
endmodule
